// ===== rtl/ups_pkg.sv
/*
  Package for the user program supervisor: window addresses, function
  codes, exception codes, status and error values, timing constants.
  Assumes a 20 MHz system clock.
*/
package ups_pkg;

  localparam int          CLK_HZ          = 20000000;
  localparam int          SLOT_US         = 1000;
  localparam int          SLOT_CYC        = (CLK_HZ / 1000000) * SLOT_US;
  localparam int          START_MAX_MS    = 200;
  localparam int          START_DLY_MS    = 2;

  localparam logic [15:0] OUT_WIN_BASE    = 16'h07D0;
  localparam logic [15:0] IN_WIN_BASE     = 16'h0BB8;
  localparam int          WIN_WORDS       = 32;
  localparam logic [15:0] WIN_REGS        = 16'h0040;

  localparam logic [7:0]  FC_RD_HOLD      = 8'h03;
  localparam logic [7:0]  FC_RD_INPUT     = 8'h04;
  localparam logic [7:0]  FC_WR_MULTI     = 8'h10;
  localparam logic [7:0]  FC_RW_MULTI     = 8'h17;

  localparam logic [7:0]  EX_NONE         = 8'h00;
  localparam logic [7:0]  EX_ILL_FUNC     = 8'h01;
  localparam logic [7:0]  EX_ILL_ADDR     = 8'h02;

  localparam logic [7:0]  CTRL_AUTO_RELQ  = 8'h05;
  localparam int          CTRL_RUN_BIT    = 0;

  localparam logic [7:0]  STAT_STOPPED    = 8'h00;
  localparam logic [7:0]  STAT_RUNNING    = 8'h01;
  localparam logic [7:0]  STAT_TIMEOUT    = 8'h04;
  localparam logic [7:0]  STAT_FAULT      = 8'h03;

  localparam logic [7:0]  ERR_NONE        = 8'h00;
  localparam logic [7:0]  ERR_MEM_PROT    = 8'h02;
  localparam logic [7:0]  ERR_TIMEOUT     = 8'h05;

  localparam int          MAP_MAX         = 16;

  typedef enum logic [2:0]
  {
    UPS_IDLE     = 3'b000,
    UPS_WAIT     = 3'b001,
    UPS_LOAD     = 3'b010,
    UPS_RUN      = 3'b011,
    UPS_STORE    = 3'b100,
    UPS_HALT     = 3'b101
  } ups_state_t;

endpackage

// ===== rtl/ups_slot_if.sv
/*
  Interface carrying the slot handshake between the scheduler and the
  window unit: copy-in strobe, copy-out strobe and slot tick.
  Assumes both ends share i_clk.
*/
`timescale 1ns/1ps
interface ups_slot_if;
  logic tick;
  logic load;
  logic store;
  logic busy;

  modport sched
  (
    output tick,
    output load,
    output store,
    input  busy
  );

  modport win
  (
    input  tick,
    input  load,
    input  store,
    output busy
  );
endinterface

// ===== rtl/ups_tick.sv
/*
  Millisecond tick generator for the slot scheduler.
  Assumes a synchronised active-low reset on i_clk.
*/
`timescale 1ns/1ps
module ups_tick
  import ups_pkg::*;
(
  // Clock and reset.
  input  wire logic i_clk,
  input  wire logic i_rst_n,
  // Tick.
  output logic      o_tick
);

  logic [14:0] cnt_q;

  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      cnt_q  <= 15'h0000;
      o_tick <= 1'b0;
    end
    else if (cnt_q == 15'(SLOT_CYC - 1))
    begin
      cnt_q  <= 15'h0000;
      o_tick <= 1'b1;
    end
    else
    begin
      cnt_q  <= cnt_q + 15'h0001;
      o_tick <= 1'b0;
    end
  end

  chk_tick_period: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    o_tick |=> !o_tick [*8])
    else $error("tick repeated too soon");

endmodule

// ===== rtl/ups_top.sv
/*
  User program supervisor top: run control, slot scheduling, timeout
  and memory protection handling, mapping limits and the register
  windows. Assumes a decoded Modbus request port and a program engine
  that reports done, yield and protection events each slot.
*/
`timescale 1ns/1ps

// Functional notes
// - Output array is a read-only window from register 2000.
// - Input array is a write-only window from register 3000.
// - Only function codes 03, 04, 10 and 17 reach the windows.
// - A loaded program starts after reset unless run bit is clear.
// - Grant a slot every 1 ms; done restarts, yield resumes.
// - Slot overrun kills the program, status 4, error 5.
// - Control value 5 selects auto relinquish; overruns tolerated.
// - Protection fault kills the program and stores its error code.
// - Each slot loads mapped values, runs, then copies back on done or yield.
// - Inputs never copied back; outputs and bidirectional are.
// - At most 16 entries per mapping list, each readable.
// - Three arrays: inputs, init parameters, outputs.
// - Copy-back takes the output array as it stood before a same-cycle program write.
// - Run bit set starts the program within 200 ms.
// - Clearing the run bit stops a running program.
// - Invalid register address answers illegal data address.
module ups_top
  import ups_pkg::*;
(
  // Clock and reset.
  input  wire logic        i_clk,
  input  wire logic        i_nrst,
  // Run control object.
  input  wire logic        i_ctrl_we,
  input  wire logic [7:0]  i_ctrl_wdata,
  input  wire logic        i_prg_loaded,
  output logic [7:0]       o_ctrl,
  output logic [7:0]       o_status,
  output logic [7:0]       o_error,
  // Program engine.
  input  wire logic        i_prg_done,
  input  wire logic        i_prg_yield,
  input  wire logic        i_mem_fault,
  output logic             o_prg_run,
  output logic             o_prg_restart,
  output logic             o_auto_relinquish_mode,
  // Mapping lists.
  input  wire logic [4:0]  i_map_cnt_in,
  input  wire logic [4:0]  i_map_cnt_out,
  input  wire logic [4:0]  i_map_cnt_io,
  input  wire logic [1:0]  i_map_sel,
  output logic [4:0]       o_map_cnt,
  output logic             o_map_load,
  output logic             o_map_store,
  output logic             o_map_store_io,
  output logic             o_map_err,
  // Fieldbus request.
  input  wire logic        i_req,
  input  wire logic [7:0]  i_fc,
  input  wire logic [15:0] i_addr,
  input  wire logic [15:0] i_wdata,
  output logic             o_ack,
  output logic [15:0]      o_rdata,
  output logic [7:0]       o_exc,
  // Program data.
  input  wire logic        i_prg_we,
  input  wire logic [4:0]  i_prg_idx,
  input  wire logic [31:0] i_prg_wdata,
  input  wire logic [4:0]  i_prg_ridx,
  output logic [31:0]      o_prg_in,
  output logic [31:0]      o_prg_init,
  // Init parameters.
  input  wire logic        i_init_we,
  input  wire logic [4:0]  i_init_idx,
  input  wire logic [31:0] i_init_wdata
);

  localparam logic [7:0] START_DLY = 8'(START_DLY_MS);

  logic       rst_s1_q;
  logic       rst_n;
  logic       tick;
  ups_state_t state_q;
  logic [7:0] ctrl_q;
  logic [7:0] status_q;
  logic [7:0] error_q;
  logic [7:0] wait_q;
  logic       boot_q;
  logic       resume_q;
  logic       load_q;
  logic       store_q;
  logic       run_bit;
  logic       auto_mode;

  ups_slot_if slot ();

  // Reset is released through two flops so every flop leaves it together.
  always_ff @(posedge i_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      rst_s1_q <= 1'b0;
      rst_n    <= 1'b0;
    end
    else
    begin
      rst_s1_q <= 1'b1;
      rst_n    <= rst_s1_q;
    end
  end

  ups_tick u_tick
  (
    .i_clk   (i_clk),
    .i_rst_n (rst_n),
    .o_tick  (tick)
  );

  assign slot.tick  = tick;
  assign slot.load  = load_q;
  assign slot.store = store_q;

  ups_window u_win
  (
    .i_clk        (i_clk),
    .i_rst_n      (rst_n),
    .slot         (slot),
    .i_req        (i_req),
    .i_fc         (i_fc),
    .i_addr       (i_addr),
    .i_wdata      (i_wdata),
    .o_ack        (o_ack),
    .o_rdata      (o_rdata),
    .o_exc        (o_exc),
    .i_prg_we     (i_prg_we),
    .i_prg_idx    (i_prg_idx),
    .i_prg_wdata  (i_prg_wdata),
    .i_prg_ridx   (i_prg_ridx),
    .o_prg_in     (o_prg_in),
    .o_prg_init   (o_prg_init),
    .i_init_we    (i_init_we),
    .i_init_idx   (i_init_idx),
    .i_init_wdata (i_init_wdata)
  );

  assign run_bit   = ctrl_q[CTRL_RUN_BIT];
  assign auto_mode = (ctrl_q == CTRL_AUTO_RELQ);

  // The run bit is set at reset so a loaded program starts by itself.
  always_ff @(posedge i_clk or negedge rst_n)
  begin
    if (!rst_n)
      ctrl_q <= 8'h01;
    else if (i_ctrl_we)
      ctrl_q <= i_ctrl_wdata;
  end

  // Scheduler: wait a short start delay, then one slot per tick.
  always_ff @(posedge i_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_q  <= UPS_IDLE;
      status_q <= STAT_STOPPED;
      error_q  <= ERR_NONE;
      wait_q   <= 8'h00;
      boot_q   <= 1'b1;
      resume_q <= 1'b0;
      load_q   <= 1'b0;
      store_q  <= 1'b0;
    end
    else
    begin
      load_q  <= 1'b0;
      store_q <= 1'b0;
      case (state_q)
        UPS_IDLE:
        begin
          status_q <= STAT_STOPPED;
          // A control write is judged by its data: the run bit register
          // only takes the new value at this same edge.
          if (i_prg_loaded && ((boot_q && run_bit) ||
              (i_ctrl_we && i_ctrl_wdata[CTRL_RUN_BIT])))
          begin
            state_q <= UPS_WAIT;
            wait_q  <= 8'h00;
            error_q <= ERR_NONE;
          end
          boot_q <= 1'b0;
        end
        UPS_WAIT:
        begin
          if (!run_bit)
            state_q <= UPS_IDLE;
          else if (tick)
          begin
            wait_q <= wait_q + 8'h01;
            if (wait_q == START_DLY - 8'h01)
            begin
              state_q  <= UPS_LOAD;
              status_q <= STAT_RUNNING;
              resume_q <= 1'b0;
              load_q   <= 1'b1;
            end
          end
        end
        UPS_LOAD:
          state_q <= UPS_RUN;
        UPS_RUN:
        begin
          if (i_mem_fault)
          begin
            state_q  <= UPS_HALT;
            status_q <= STAT_FAULT;
            error_q  <= ERR_MEM_PROT;
          end
          else if (!run_bit)
            state_q <= UPS_IDLE;
          else if (i_prg_done || i_prg_yield)
          begin
            state_q  <= UPS_STORE;
            resume_q <= i_prg_yield;
            store_q  <= 1'b1;
          end
          else if (tick && !auto_mode)
          begin
            state_q  <= UPS_HALT;
            status_q <= STAT_TIMEOUT;
            error_q  <= ERR_TIMEOUT;
          end
        end
        UPS_STORE:
        begin
          if (!run_bit)
            state_q <= UPS_IDLE;
          else if (tick)
          begin
            state_q <= UPS_LOAD;
            load_q  <= 1'b1;
          end
        end
        UPS_HALT:
          if (!run_bit)
            state_q <= UPS_IDLE;
        default:
          state_q <= UPS_IDLE;
      endcase
    end
  end

  assign o_ctrl                 = ctrl_q;
  assign o_status               = status_q;
  assign o_error                = error_q;
  assign o_prg_run              = (state_q == UPS_RUN);
  assign o_prg_restart          = load_q && !resume_q;
  assign o_auto_relinquish_mode = auto_mode;
  assign o_map_load             = load_q;
  assign o_map_store            = store_q;
  assign o_map_store_io         = store_q;

  always_comb
  begin
    case (i_map_sel)
      2'h0:    o_map_cnt = i_map_cnt_in;
      2'h1:    o_map_cnt = i_map_cnt_out;
      2'h2:    o_map_cnt = i_map_cnt_io;
      default: o_map_cnt = 5'h00;
    endcase
  end

  assign o_map_err = (i_map_cnt_in > 5'(MAP_MAX)) ||
                     (i_map_cnt_out > 5'(MAP_MAX)) ||
                     (i_map_cnt_io > 5'(MAP_MAX));

  chk_timeout_code: assert property (@(posedge i_clk) disable iff (!rst_n)
    (state_q == UPS_RUN && tick && !auto_mode && !i_mem_fault && run_bit &&
     !i_prg_done && !i_prg_yield) |=>
    (status_q == STAT_TIMEOUT && error_q == ERR_TIMEOUT))
    else $error("overrun not reported as timeout");
  chk_auto_keep: assert property (@(posedge i_clk) disable iff (!rst_n)
    (state_q == UPS_RUN && auto_mode && !i_mem_fault && run_bit) |=>
    (error_q != ERR_TIMEOUT))
    else $error("auto relinquish mode terminated program");
  chk_fault_halt: assert property (@(posedge i_clk) disable iff (!rst_n)
    (state_q == UPS_RUN && i_mem_fault) |=>
    (state_q == UPS_HALT && error_q == ERR_MEM_PROT))
    else $error("protection fault not handled");
  chk_load_run: assert property (@(posedge i_clk) disable iff (!rst_n)
    load_q |=> o_prg_run)
    else $error("slot did not follow copy-in");
  chk_stop_bit: assert property (@(posedge i_clk) disable iff (!rst_n)
    (o_prg_run && !run_bit && !i_mem_fault) |=> !o_prg_run)
    else $error("program kept running after stop");
  chk_store_after: assert property (@(posedge i_clk) disable iff (!rst_n)
    (o_prg_run && run_bit && !i_mem_fault && i_prg_done) |=>
    (store_q && state_q == UPS_STORE))
    else $error("copy-back missing after slot");

endmodule

// ===== rtl/ups_window.sv
/*
  Modbus register windows over the output and input exchange arrays,
  plus the init parameter array and the copy-in and copy-out images.
  Assumes a decoded request interface already freed of framing and CRC.
*/
`timescale 1ns/1ps
module ups_window
  import ups_pkg::*;
(
  // Clock and reset.
  input  wire logic        i_clk,
  input  wire logic        i_rst_n,
  // Slot handshake.
  ups_slot_if.win          slot,
  // Fieldbus request.
  input  wire logic        i_req,
  input  wire logic [7:0]  i_fc,
  input  wire logic [15:0] i_addr,
  input  wire logic [15:0] i_wdata,
  output logic             o_ack,
  output logic [15:0]      o_rdata,
  output logic [7:0]       o_exc,
  // Program side.
  input  wire logic        i_prg_we,
  input  wire logic [4:0]  i_prg_idx,
  input  wire logic [31:0] i_prg_wdata,
  input  wire logic [4:0]  i_prg_ridx,
  output logic [31:0]      o_prg_in,
  output logic [31:0]      o_prg_init,
  // Init parameters.
  input  wire logic        i_init_we,
  input  wire logic [4:0]  i_init_idx,
  input  wire logic [31:0] i_init_wdata
);

  logic [31:0] out_arr  [WIN_WORDS];
  logic [31:0] out_img  [WIN_WORDS];
  logic [31:0] in_arr   [WIN_WORDS];
  logic [31:0] in_img   [WIN_WORDS];
  logic [31:0] init_arr [WIN_WORDS];
  logic [15:0] lo_hold_q;
  logic        in_out_win;
  logic        in_in_win;
  logic [15:0] off;
  logic        fc_ok;
  logic        is_rd;

  function automatic logic in_win(input logic [15:0] a,
                                  input logic [15:0] base);
    in_win = (a >= base) && (a < base + WIN_REGS);
  endfunction

  assign in_out_win = in_win(i_addr, OUT_WIN_BASE);
  assign in_in_win  = in_win(i_addr, IN_WIN_BASE);
  assign off        = in_out_win ? i_addr - OUT_WIN_BASE
                                 : i_addr - IN_WIN_BASE;
  assign fc_ok      = (i_fc == FC_RD_HOLD) || (i_fc == FC_RD_INPUT) ||
                      (i_fc == FC_WR_MULTI) || (i_fc == FC_RW_MULTI);
  assign is_rd      = (i_fc == FC_RD_HOLD) || (i_fc == FC_RD_INPUT);
  assign slot.busy  = 1'b0;

  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      o_ack     <= 1'b0;
      o_rdata   <= 16'h0000;
      o_exc     <= EX_NONE;
      lo_hold_q <= 16'h0000;
    end
    else
    begin
      o_ack <= i_req;
      if (i_req)
      begin
        o_rdata <= 16'h0000;
        if (!fc_ok)
          o_exc <= EX_ILL_FUNC;
        else if (!(in_out_win || in_in_win))
          o_exc <= EX_ILL_ADDR;
        else if ((in_in_win && is_rd) || (in_out_win && !is_rd))
          o_exc <= EX_ILL_ADDR;
        else
        begin
          o_exc <= EX_NONE;
          if (is_rd)
            o_rdata <= off[0] ? out_img[off[5:1]][31:16]
                              : out_img[off[5:1]][15:0];
          else if (!off[0])
            lo_hold_q <= i_wdata;
        end
      end
    end
  end

  // Input words land as a pair: the low half waits for the high half.
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      for (int i = 0; i < WIN_WORDS; i++)
      begin
        in_arr[i]  <= 32'h0000_0000;
        in_img[i]  <= 32'h0000_0000;
        out_img[i] <= 32'h0000_0000;
      end
    end
    else
    begin
      if (i_req && fc_ok && in_in_win && !is_rd && off[0])
        in_arr[off[5:1]] <= {i_wdata, lo_hold_q};
      if (slot.load)
        for (int i = 0; i < WIN_WORDS; i++)
          in_img[i] <= in_arr[i];
      if (slot.store)
        for (int i = 0; i < WIN_WORDS; i++)
          out_img[i] <= out_arr[i];
    end
  end

  // Program writes go straight to the output array, init writes to the init array.
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      for (int i = 0; i < WIN_WORDS; i++)
      begin
        out_arr[i]  <= 32'h0000_0000;
        init_arr[i] <= 32'h0000_0000;
      end
    end
    else
    begin
      if (i_prg_we)
        out_arr[i_prg_idx] <= i_prg_wdata;
      if (i_init_we)
        init_arr[i_init_idx] <= i_init_wdata;
    end
  end

  assign o_prg_in   = in_img[i_prg_ridx];
  assign o_prg_init = init_arr[i_prg_ridx];

  chk_rd_in_win: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (i_req && fc_ok && in_in_win && is_rd) |=> (o_exc == EX_ILL_ADDR))
    else $error("read of input window not rejected");
  chk_bad_fc: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (i_req && !fc_ok) |=> (o_ack && o_exc == EX_ILL_FUNC))
    else $error("bad function code accepted");

endmodule

// ===== verif/ups_master.sv
/*
  Fieldbus master model: one decoded register access at a time.
  Assumes the block answers every request with a one-cycle acknowledge.
*/
`timescale 1ns/1ps
module ups_master
(
  // Clock.
  input  wire logic        i_clk,
  // Request.
  output logic             o_req,
  output logic [7:0]       o_fc,
  output logic [15:0]      o_addr,
  output logic [15:0]      o_wdata,
  // Answer.
  input  wire logic        i_ack,
  input  wire logic [15:0] i_rdata,
  input  wire logic [7:0]  i_exc
);
  int gap  = 0;
  int miss = 0;

  initial
  begin
    o_req   = 1'b0;
    o_fc    = 8'hFF;
    o_addr  = 16'hFFFF;
    o_wdata = 16'hFFFF;
  end

  // Fields are inverted once taken, so a late latch sees garbage.
  task automatic xfer(input logic [7:0] fc, input logic [15:0] addr,
                      input logic [15:0] wd, output logic [15:0] rd,
                      output logic [7:0] ex);
    begin
      repeat (gap) @(negedge i_clk);
      @(negedge i_clk);
      o_req   = 1'b1;
      o_fc    = fc;
      o_addr  = addr;
      o_wdata = wd;
      // The answer stands only in the cycle after the taking edge.
      @(negedge i_clk);
      if (i_ack !== 1'b1)
        miss++;
      rd      = i_rdata;
      ex      = i_exc;
      o_req   = 1'b0;
      o_fc    = ~fc;
      o_addr  = ~addr;
      o_wdata = ~wd;
    end
  endtask

  // Whole words only, low half at the even register first.
  task automatic wr32(input logic [7:0] fc, input logic [15:0] addr,
                      input logic [31:0] w, output logic [7:0] ex);
    logic [15:0] rd;
    logic [7:0]  e0;
    begin
      xfer(fc, addr, w[15:0], rd, e0);
      xfer(fc, addr + 16'h0001, w[31:16], rd, ex);
      if (e0 !== 8'h00)
        ex = e0;
    end
  endtask

  task automatic rd32(input logic [7:0] fc, input logic [15:0] addr,
                      output logic [31:0] w, output logic [7:0] ex);
    logic [7:0] e0;
    begin
      xfer(fc, addr, 16'h0000, w[15:0], e0);
      xfer(fc, addr + 16'h0001, 16'h0000, w[31:16], ex);
      if (e0 !== 8'h00)
        ex = e0;
    end
  endtask
endmodule

// ===== verif/ups_top_tb.sv
/*
  Self-checking bench for the user program supervisor top.
  Assumes the bench drives all inputs at the falling clock edge.
*/
`timescale 1ns/1ps
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin err_count++; \
  $display("BAD t=%0t got %h exp %h", $time, g, e); end end
module ups_top_tb
  import ups_pkg::*;
;
  logic        clk, nrst, cwe, loaded, done, yld, fault, pwe, iwe;
  logic [7:0]  cwd, ctrl, stat, err, fc, exc, ex;
  logic        run, rst, auto, mld, mst, msio, merr, req, ack;
  logic [4:0]  cin, cout, cio, cnt, pidx, ridx, iidx;
  logic [1:0]  sel;
  logic [15:0] addr, wd, rdat;
  logic [31:0] pwd, pin, pinit, iwd, w;
  int          err_count = 0;
  int          check_count = 0;
  int          cyc = 0;
  int          n;
  localparam logic [31:0] W0 = 32'h89AB_CDEF;
  localparam logic [31:0] W1 = 32'h1357_9BDF;
  localparam logic [31:0] W31 = 32'hF00D_8001;
  localparam logic [31:0] WP = 32'hCAFE_0123;

  ups_top dut (.i_clk(clk), .i_nrst(nrst), .i_ctrl_we(cwe),
    .i_ctrl_wdata(cwd), .i_prg_loaded(loaded), .o_ctrl(ctrl),
    .o_status(stat), .o_error(err), .i_prg_done(done), .i_prg_yield(yld),
    .i_mem_fault(fault), .o_prg_run(run), .o_prg_restart(rst),
    .o_auto_relinquish_mode(auto), .i_map_cnt_in(cin),
    .i_map_cnt_out(cout), .i_map_cnt_io(cio), .i_map_sel(sel),
    .o_map_cnt(cnt), .o_map_load(mld), .o_map_store(mst),
    .o_map_store_io(msio), .o_map_err(merr), .i_req(req), .i_fc(fc),
    .i_addr(addr), .i_wdata(wd), .o_ack(ack), .o_rdata(rdat), .o_exc(exc),
    .i_prg_we(pwe), .i_prg_idx(pidx), .i_prg_wdata(pwd),
    .i_prg_ridx(ridx), .o_prg_in(pin), .o_prg_init(pinit),
    .i_init_we(iwe), .i_init_idx(iidx), .i_init_wdata(iwd));

  ups_master m (.i_clk(clk), .o_req(req), .o_fc(fc), .o_addr(addr),
    .o_wdata(wd), .i_ack(ack), .i_rdata(rdat), .i_exc(exc));

  initial
  begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  task automatic results();
    err_count += m.miss;
    $display("checks %0d mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  // A full run spends about four slots; the ceiling leaves most of one.
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 95000)
    begin
      err_count++;
      $display("BAD t=%0t run hung", $time);
      results();
    end
  end

  task automatic ctl(input logic [7:0] v);
    @(negedge clk);
    cwe = 1'b1;
    cwd = v;
    @(negedge clk);
    cwe = 1'b0;
    cwd = ~v;
    @(negedge clk);
  endtask

  // Bounded wait: 0 copy-in, 1 copy-out, 2 timeout status.
  task automatic wait_sig(input int which, input int lim, output int k);
    for (k = 0; k < lim; k++)
    begin
      @(posedge clk);
      #1;
      if ((which == 0 && mld === 1'b1) || (which == 1 && mst === 1'b1) ||
          (which == 2 && stat === STAT_TIMEOUT))
        break;
    end
  endtask

  task automatic refuse(input logic [7:0] f, input logic [15:0] a,
                        input logic [7:0] e);
    m.xfer(f, a, 16'h5A5A, w[15:0], ex);
    `CHK(ex, e)
  endtask

  task automatic t_reset();
    `CHK(ctrl, 8'h01)
    `CHK(stat, STAT_STOPPED)
    `CHK(err, ERR_NONE)
    `CHK(auto, 1'b0)
    $display("test reset done");
  endtask

  task automatic t_windows();
    m.wr32(FC_WR_MULTI, IN_WIN_BASE, W0, ex);
    `CHK(ex, EX_NONE)
    m.gap = 3;
    m.wr32(FC_RW_MULTI, IN_WIN_BASE + 16'h0002, W1, ex);
    `CHK(ex, EX_NONE)
    m.gap = 0;
    m.wr32(FC_WR_MULTI, IN_WIN_BASE + 16'h003E, W31, ex);
    `CHK(ex, EX_NONE)
    @(negedge clk);
    pwe = 1'b1;
    pidx = 5'h03;
    pwd = WP;
    iwe = 1'b1;
    iidx = 5'h1F;
    iwd = W1;
    @(negedge clk);
    pwe = 1'b0;
    iwe = 1'b0;
    ridx = 5'h1F;
    #1;
    `CHK(pinit, W1)
    m.rd32(FC_RD_INPUT, OUT_WIN_BASE + 16'h003E, w, ex);
    `CHK(ex, EX_NONE)
    m.rd32(FC_RD_HOLD, OUT_WIN_BASE + 16'h0006, w, ex);
    `CHK(w, 32'h0000_0000)
    $display("test windows done");
  endtask

  task automatic t_refuse();
    refuse(8'h06, OUT_WIN_BASE, EX_ILL_FUNC);
    refuse(FC_RD_HOLD, OUT_WIN_BASE - 16'h0001, EX_ILL_ADDR);
    refuse(FC_RD_HOLD, OUT_WIN_BASE + WIN_REGS, EX_ILL_ADDR);
    refuse(FC_WR_MULTI, IN_WIN_BASE + WIN_REGS, EX_ILL_ADDR);
    refuse(FC_RD_HOLD, IN_WIN_BASE, EX_ILL_ADDR);
    refuse(FC_WR_MULTI, OUT_WIN_BASE, EX_ILL_ADDR);
    $display("test refusals done");
  endtask

  task automatic t_maps();
    @(negedge clk);
    cin = 5'h10;
    cout = 5'h05;
    cio = 5'h09;
    sel = 2'h0;
    #1;
    `CHK({cnt, merr}, {5'h10, 1'b0})
    sel = 2'h1;
    #1;
    `CHK(cnt, 5'h05)
    sel = 2'h2;
    cio = 5'h11;
    #1;
    `CHK({cnt, merr}, {5'h11, 1'b1})
    cio = 5'h09;
    $display("test mapping done");
  endtask

  task automatic t_slot();
    wait_sig(0, 45000, n);
    `CHK({n < 45000, rst, stat}, {1'b1, 1'b1, STAT_RUNNING})
    repeat (2) @(negedge clk);
    `CHK(run, 1'b1)
    ridx = 5'h00;
    #1;
    `CHK(pin, W0)
    ridx = 5'h01;
    #1;
    `CHK(pin, W1)
    ridx = 5'h1F;
    #1;
    `CHK(pin, W31)
    done = 1'b1;
    fork
      begin
        @(negedge clk);
        done = 1'b0;
      end
      wait_sig(1, 6, n);
    join
    `CHK({n < 6, msio}, 2'b11)
    m.rd32(FC_RD_HOLD, OUT_WIN_BASE + 16'h0006, w, ex);
    `CHK(w, WP)
    wait_sig(0, 20100, n);
    `CHK({n < 20100, rst}, 2'b11)
    wait_sig(2, 20100, n);
    `CHK({n < 20100, err, run}, {1'b1, ERR_TIMEOUT, 1'b0})
    ctl(8'h00);
    @(negedge clk);
    `CHK(stat, STAT_STOPPED)
    ctl(CTRL_AUTO_RELQ);
    `CHK({ctrl, auto}, {CTRL_AUTO_RELQ, 1'b1})
    $display("test slot done");
  endtask

  initial
  begin
    nrst = 1'b0;
    {cwe, done, yld, fault, pwe, iwe} = '0;
    loaded = 1'b1;
    cwd = 8'h00;
    {cin, cout, cio, pidx, ridx, iidx, sel} = '0;
    pwd = '0;
    iwd = '0;
    repeat (12) @(negedge clk);
    nrst = 1'b1;
    repeat (3) @(negedge clk);
    t_reset();
    t_windows();
    t_refuse();
    t_maps();
    t_slot();
    results();
  end
endmodule
